// file: rtl/pmc_pkg.sv
package pmc_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_IO_PULL = 8'h04;
  localparam logic [7:0] OFS_REFBUF = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // Low-power mode select codes in the control register.
  localparam logic [1:0] SEL_SLEEP = 2'h0;
  localparam logic [1:0] SEL_STOP = 2'h1;
  localparam logic [1:0] SEL_STANDBY = 2'h2;
  localparam logic [1:0] SEL_SHUTDOWN = 2'h3;

  // Reference buffer levels: 2.048 V, 2.5 V and 2.9 V; code 3 is reserved.
  localparam logic [1:0] REF_2V048 = 2'h0;
  localparam logic [1:0] REF_2V5 = 2'h1;
  localparam logic [1:0] REF_2V9 = 2'h2;
  localparam logic [1:0] REF_RESERVED = 2'h3;

  // Status register field positions.
  localparam int ST_MODE = 0;
  localparam int ST_PVD_LOW = 3;
  localparam int ST_BATTERY = 4;
  localparam int ST_PVD_FLAG = 5;
  localparam int ST_CAUSE = 6;

  // Positions inside the synchroniser bank.
  localparam int SY_BOR = 0;
  localparam int SY_PVD = 1;
  localparam int SY_VDD = 2;
  localparam int SY_WAKE = 3;
  localparam int SY_RSTN = 4;
  localparam int SY_W = 5;

  // Last reset cause codes.
  localparam logic [1:0] CAUSE_POWER = 2'h0;
  localparam logic [1:0] CAUSE_PIN = 2'h1;
  localparam logic [1:0] CAUSE_WDG = 2'h2;
  localparam logic [1:0] CAUSE_WAKE = 2'h3;

  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,
    MODE_SLEEP = 3'b001,
    MODE_LPRUN = 3'b010,
    MODE_LPSLEEP = 3'b011,
    MODE_STOP = 3'b100,
    MODE_STANDBY = 3'b101,
    MODE_SHUTDOWN = 3'b110
  } pmc_mode_t;

  typedef struct packed {
    logic io_release;
    logic wake_pol;
    logic wake_en;
    logic charge_req;
    logic [1:0] pvd_edge;
    logic pvd_en;
    logic [1:0] range;
    logic lp_run;
    logic [1:0] lp_sel;
  } pmc_ctrl_t;

  typedef struct packed {
    logic main_regulator;
    logic low_power_regulator;
    logic regulator_hiz;
    logic cpu_clk;
    logic core_clk;
    logic pll;
    logic internal_rc_fast;
    logic fast_crystal_osc;
    logic internal_rc_slow;
    logic supply_drop_reset;
    logic supply_threshold_detector;
    logic io_pull_apply;
  } pmc_power_t;

  // Reset values.
  localparam pmc_ctrl_t CTRL_RST = 12'h008;
  localparam logic [15:0] IO_PULL_RST = 16'h0000;
  localparam logic [1:0] REF_RST = 2'h0;
  localparam logic [SY_W-1:0] SYNC_RST = 5'h14;

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic wake_prev;
    logic pvd_prev;
    pmc_mode_t mode;
    pmc_ctrl_t ctrl;
    logic [15:0] io_pull;
    logic [1:0] ref_level;
    logic pvd_flag;
    logic [1:0] cause;
    pmc_power_t pwr;
    logic sys_reset;
    logic pullup_en;
    logic io_analog;
    logic battery;
    logic charge_en;
    logic pvd_irq;
    logic [31:0] rdata;
  } pmc_state_t;

endpackage

// file: rtl/pmc_top.sv
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Hold reset while supply below drop threshold.
// - Detector interrupt on falling, rising or both.
// - Main regulator in run/sleep, low-power in lp-run/lp-sleep/stop.
// - Standby/shutdown: both regulators off, outputs hi-Z.
// - Start in run; low power only on request.
// - Sleep stops CPU only; interrupt wakes.
// - Low-power sleep only from low-power run.
// - Stop halts core clocks, PLL, fast oscillators.
// - Stop lets peripherals borrow fast RC oscillator.
// - Standby: regulator, PLL, fast oscillators off; reset kept.
// - Standby applies software chosen I/O pulls.
// - Standby exits: pin, watchdog, wake, RTC, crystal.
// - Shutdown drops slow RC and all supervision.
// - Shutdown exits exclude crystal failure.
// - I/Os analog in reset; internal reset drops pull-up.
// - Battery takes over when main supply absent.
// - Charger only while main supply present.
// - No battery exit on interrupts or RTC; only standby/shutdown exits are gated, interrupts still end sleep/stop.
// - Reference buffer offers three selectable levels.
module pmc_top
  import pmc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic [pmc_pkg::ADDR_W-1:0] addr,
  input wire logic [pmc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pmc_pkg::DATA_W-1:0] rdata,
  input wire logic cpu_wait,
  input wire logic irq_event,
  input wire logic wake_clk_req,
  input wire logic independent_watchdog,
  input wire logic rtc_event,
  input wire logic slow_crystal_fail,
  input wire logic supply_low,
  input wire logic detector_low,
  input wire logic supply_present,
  input wire logic wakeup_pin,
  input wire logic external_reset_pin_n,
  output pmc_pkg::pmc_power_t power,
  output pmc_pkg::pmc_mode_t mode,
  output logic [1:0] regulator_range,
  output logic [1:0] reference_level_select,
  output logic [15:0] io_pull,
  output logic system_reset,
  output logic reset_pullup_en,
  output logic io_analog,
  output logic battery_select,
  output logic charge_en,
  output logic detector_irq
);
  import pmc_pkg::*;

  pmc_state_t s;
  pmc_state_t n;

  // Per-mode supply and clock plan; the fast RC request only matters in stop.
  function automatic pmc_power_t pmc_plan(input pmc_mode_t m, input logic rc_req);
    pmc_power_t p;
    p = '0;
    unique case (m)
      MODE_RUN: begin
        p.main_regulator = 1'b1;
        p.cpu_clk = 1'b1;
        p.core_clk = 1'b1;
        p.pll = 1'b1;
        p.internal_rc_fast = 1'b1;
        p.fast_crystal_osc = 1'b1;
      end
      MODE_SLEEP: begin
        p.main_regulator = 1'b1;
        p.core_clk = 1'b1;
        p.pll = 1'b1;
        p.internal_rc_fast = 1'b1;
        p.fast_crystal_osc = 1'b1;
      end
      MODE_LPRUN: begin
        p.low_power_regulator = 1'b1;
        p.cpu_clk = 1'b1;
        p.core_clk = 1'b1;
        p.internal_rc_fast = 1'b1;
      end
      MODE_LPSLEEP: begin
        p.low_power_regulator = 1'b1;
        p.core_clk = 1'b1;
        p.internal_rc_fast = 1'b1;
      end
      // core clocks off, RC on request
      MODE_STOP: begin
        p.low_power_regulator = 1'b1;
        p.internal_rc_fast = rc_req;
      end
      MODE_STANDBY: begin
        p.regulator_hiz = 1'b1;
        p.io_pull_apply = 1'b1;
      end
      // everything but the RTC domain off
      MODE_SHUTDOWN: begin
        p.regulator_hiz = 1'b1;
      end
      default: begin
        p.main_regulator = 1'b1;
      end
    endcase
    // slow RC and drop reset off only in shutdown; threshold detector off in standby too
    p.internal_rc_slow = (m != MODE_SHUTDOWN);
    p.supply_drop_reset = (m != MODE_SHUTDOWN);
    p.supply_threshold_detector = (m != MODE_SHUTDOWN) && (m != MODE_STANDBY);
    return p;
  endfunction

  // Target of a wait instruction for each select code; sleep depends on where the CPU halted.
  // lp-sleep from lp-run
  function automatic pmc_mode_t pmc_lp_target(input logic [1:0] sel, input logic from_lp);
    pmc_mode_t t;
    t = MODE_RUN;
    unique case (sel)
      SEL_SLEEP: begin
        if (from_lp) begin
          t = MODE_LPSLEEP;
        end else begin
          t = MODE_SLEEP;
        end
      end
      SEL_STOP: begin
        t = MODE_STOP;
      end
      SEL_STANDBY: begin
        t = MODE_STANDBY;
      end
      SEL_SHUTDOWN: begin
        t = MODE_SHUTDOWN;
      end
    endcase
    return t;
  endfunction

  logic bor_low;
  logic pvd_low;
  logic vdd_ok;
  logic wake_lvl;
  logic rst_pin_low;
  logic wake_edge;
  logic pvd_event;
  logic exit_event;
  logic hard_reset;
  logic [1:0] hard_cause;

  // Synchronised views of the asynchronous pins and comparators.
  assign bor_low = s.sync2[SY_BOR];
  assign pvd_low = s.sync2[SY_PVD];
  assign vdd_ok = s.sync2[SY_VDD];
  assign wake_lvl = s.sync2[SY_WAKE];
  assign rst_pin_low = ~s.sync2[SY_RSTN];

  // Wake pin edge of the configured polarity; a set polarity bit selects falling.
  assign wake_edge = s.ctrl.wake_en &
    (s.ctrl.wake_pol ? (s.wake_prev & ~wake_lvl) : (~s.wake_prev & wake_lvl));

  assign pvd_event = s.ctrl.pvd_en & s.pwr.supply_threshold_detector &
    ((s.ctrl.pvd_edge[0] & pvd_low & ~s.pvd_prev) |
     (s.ctrl.pvd_edge[1] & ~pvd_low & s.pvd_prev));

  // Exit from standby or shutdown behaves like a reset, since contents are lost.
  // On battery the standby circuitry has no supply to answer with, so wake pin, RTC and crystal-fail exits are gated.
  always_comb begin
    exit_event = 1'b0;
    if (vdd_ok) begin
      if (s.mode == MODE_STANDBY) begin
        exit_event = wake_edge | rtc_event | slow_crystal_fail;
      end
      if (s.mode == MODE_SHUTDOWN) begin
        exit_event = wake_edge | rtc_event;
      end
    end
  end

  // Reset sources, with the supply drop having priority in the cause code.
  // Pin and watchdog resets act in every mode, also while the battery holds the backup domain.
  always_comb begin
    hard_reset = 1'b1;
    hard_cause = CAUSE_POWER;
    if (bor_low && s.pwr.supply_drop_reset) begin
      hard_cause = CAUSE_POWER;
    end else if (rst_pin_low) begin
      hard_cause = CAUSE_PIN;
    end else if (independent_watchdog) begin
      hard_cause = CAUSE_WDG;
    end else if (exit_event) begin
      hard_cause = CAUSE_WAKE;
    end else begin
      hard_reset = 1'b0;
    end
  end

  // Next-state logic for the whole block.
  always_comb begin
    n = s;
    n.sync1 = {external_reset_pin_n, wakeup_pin, supply_present, detector_low, supply_low};
    n.sync2 = s.sync1;
    n.wake_prev = wake_lvl;
    n.pvd_prev = pvd_low;
    n.rdata = '0;

    // Software writes; unmapped offsets are ignored.
    // A status write only clears the detector flag, since the other status bits are read-only.
    if (wr) begin
      unique case (addr)
        OFS_CTRL: n.ctrl = wdata[$bits(pmc_ctrl_t)-1:0];
        OFS_IO_PULL: n.io_pull = wdata[15:0];
        // reserved level code is not stored
        OFS_REFBUF: begin
          if (wdata[1:0] != REF_RESERVED) begin
            n.ref_level = wdata[1:0];
          end
        end
        OFS_STATUS: begin
          if (wdata[ST_PVD_FLAG]) begin
            n.pvd_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (pvd_event) begin
      n.pvd_flag = 1'b1;
    end

    // Software reads; unmapped offsets return zero.
    // The read word is registered, so it stands for exactly one cycle after the strobe.
    if (rd) begin
      unique case (addr)
        OFS_CTRL: n.rdata = {{(32 - $bits(pmc_ctrl_t)){1'b0}}, s.ctrl};
        OFS_IO_PULL: n.rdata = {16'h0000, s.io_pull};
        OFS_REFBUF: n.rdata = {30'h0, s.ref_level};
        OFS_STATUS: begin
          n.rdata[ST_MODE +: 3] = s.mode;
          n.rdata[ST_PVD_LOW] = pvd_low;
          n.rdata[ST_BATTERY] = s.battery;
          n.rdata[ST_PVD_FLAG] = s.pvd_flag;
          n.rdata[ST_CAUSE +: 2] = s.cause;
        end
        default: n.rdata = '0;
      endcase
    end

    // Mode sequencer.
    unique case (s.mode)
      MODE_RUN: begin
        if (s.ctrl.lp_run) begin
          n.mode = MODE_LPRUN;
        end else if (cpu_wait) begin
          n.mode = pmc_lp_target(s.ctrl.lp_sel, 1'b0);
        end
      end
      // low-power sleep reached from here only
      MODE_LPRUN: begin
        if (!s.ctrl.lp_run) begin
          n.mode = MODE_RUN;
        end else if (cpu_wait) begin
          n.mode = pmc_lp_target(s.ctrl.lp_sel, 1'b1);
        end
      end
      MODE_SLEEP: begin
        if (irq_event) begin
          n.mode = MODE_RUN;
        end
      end
      MODE_LPSLEEP: begin
        if (irq_event) begin
          n.mode = MODE_LPRUN;
        end
      end
      // Stop always wakes into run; a still-set low-power run bit moves on a cycle later.
      // This keeps a single exit path and costs one cycle at the main regulator.
      MODE_STOP: begin
        if (irq_event) begin
          n.mode = MODE_RUN;
        end
      end
      MODE_STANDBY: ;
      MODE_SHUTDOWN: ;
      default: n.mode = MODE_RUN;
    endcase

    // any reset returns to run and loses settings
    n.sys_reset = hard_reset;
    if (hard_reset) begin
      n.mode = MODE_RUN;
      n.ctrl = CTRL_RST;
      n.io_pull = IO_PULL_RST;
      n.ref_level = REF_RST;
      n.pvd_flag = 1'b0;
      n.cause = hard_cause;
    end

    // The plan follows the next mode, so enables change on the same edge as the mode.
    // Without this the power outputs would lag one cycle behind the mode they describe.
    n.pwr = pmc_plan(n.mode, wake_clk_req);
    n.pvd_irq = n.pvd_flag;
    // analog I/Os until software releases them
    n.io_analog = hard_reset | ~n.ctrl.io_release;
    n.pullup_en = ~(hard_reset && (hard_cause != CAUSE_PIN));
    n.battery = ~vdd_ok;
    n.charge_en = n.ctrl.charge_req & vdd_ok;
  end

  // Single state register; the reset state is run with supervision enabled.
  // Synchronisers restart at the pins' idle levels, so no false edge follows reset.
  always_ff @(posedge clock) begin
    if (srst) begin
      s.sync1 <= SYNC_RST;
      s.sync2 <= SYNC_RST;
      s.wake_prev <= 1'b0;
      s.pvd_prev <= 1'b0;
      s.mode <= MODE_RUN;
      s.ctrl <= CTRL_RST;
      s.io_pull <= IO_PULL_RST;
      s.ref_level <= REF_RST;
      s.pvd_flag <= 1'b0;
      s.cause <= CAUSE_POWER;
      s.pwr <= pmc_plan(MODE_RUN, 1'b0);
      s.sys_reset <= 1'b1;
      s.pullup_en <= 1'b0;
      s.io_analog <= 1'b1;
      s.battery <= 1'b0;
      s.charge_en <= 1'b0;
      s.pvd_irq <= 1'b0;
      s.rdata <= '0;
    end else begin
      s <= n;
    end
  end

  // Outputs straight from the state register.
  assign rdata = s.rdata;
  assign power = s.pwr;
  assign mode = s.mode;
  assign regulator_range = s.ctrl.range;
  assign reference_level_select = s.ref_level;
  assign io_pull = s.io_pull;
  assign system_reset = s.sys_reset;
  assign reset_pullup_en = s.pullup_en;
  assign io_analog = s.io_analog;
  assign battery_select = s.battery;
  assign charge_en = s.charge_en;
  assign detector_irq = s.pvd_irq;

endmodule

`default_nettype wire

// file: tb/pmc_chk.sv
`timescale 1ns/100ps
`default_nettype none

// Power-plan, mode-entry, reset and battery checks; all on one clock, reset suspends them.
module pmc_chk
  import pmc_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic cpu_wait,
  input wire logic wake_clk_req,
  input wire logic supply_low,
  input wire logic supply_present,
  input wire pmc_pkg::pmc_power_t power,
  input wire pmc_pkg::pmc_mode_t mode,
  input wire logic system_reset,
  input wire logic io_analog,
  input wire logic battery_select,
  input wire logic charge_en
);
  import pmc_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_run_main_reg: assert property (mode inside {MODE_RUN, MODE_SLEEP} |-> power.main_regulator && !power.low_power_regulator)
    else $error("main regulator not alone in run or sleep");
  a_lp_reg_used: assert property (mode inside {MODE_LPRUN, MODE_LPSLEEP, MODE_STOP} |-> power.low_power_regulator && !power.main_regulator)
    else $error("low-power regulator not alone in low-power modes");
  a_off_regs_hiz: assert property (mode inside {MODE_STANDBY, MODE_SHUTDOWN} |-> power.regulator_hiz && !power.main_regulator && !power.low_power_regulator && !power.pll && !power.fast_crystal_osc)
    else $error("regulators or fast clocks alive in standby or shutdown");
  a_stop_clocks: assert property (mode == MODE_STOP |-> !power.core_clk && !power.pll && !power.fast_crystal_osc && power.internal_rc_slow && power.supply_drop_reset)
    else $error("stop mode clock plan wrong");
  a_stop_rc_loan: assert property ((mode == MODE_STOP && wake_clk_req) [*3] |-> power.internal_rc_fast)
    else $error("fast RC not lent during stop");
  a_shutdown_sup: assert property (mode == MODE_SHUTDOWN |-> !power.supply_drop_reset && !power.internal_rc_slow && !power.supply_threshold_detector)
    else $error("supervision alive in shutdown");
  a_standby_bor: assert property (mode == MODE_STANDBY |-> power.supply_drop_reset)
    else $error("drop reset off in standby");
  a_sleep_cpu: assert property (mode inside {MODE_SLEEP, MODE_LPSLEEP} |-> !power.cpu_clk && power.core_clk)
    else $error("sleep clock plan wrong");
  a_lpsleep_entry: assert property ($changed(mode) && mode == MODE_LPSLEEP |-> $past(mode) == MODE_LPRUN && $past(cpu_wait))
    else $error("low-power sleep entered from wrong mode");
  a_low_power_req: assert property ($past(mode) == MODE_RUN && !(mode inside {MODE_RUN, MODE_LPRUN}) |-> $past(cpu_wait))
    else $error("low-power mode without CPU halt");
  a_drop_holds: assert property ((supply_low && mode != MODE_SHUTDOWN) [*4] |-> system_reset && mode == MODE_RUN)
    else $error("no reset on supply drop");
  a_battery_swap: assert property ((!supply_present) [*4] |-> battery_select && !charge_en)
    else $error("battery switchover or charger wrong");
  a_reset_analog: assert property (system_reset |-> io_analog)
    else $error("pins not analog during reset");

  c_lpsleep: cover property (mode == MODE_LPSLEEP);
  c_standby_exit: cover property (mode == MODE_STANDBY ##[1:20] mode == MODE_RUN);
  c_battery_standby: cover property (battery_select && mode == MODE_STANDBY);
endmodule

bind pmc_top pmc_chk u_chk (.clock, .srst, .cpu_wait, .wake_clk_req, .supply_low, .supply_present, .power, .mode,
  .system_reset, .io_analog, .battery_select, .charge_en);

`default_nettype wire

// file: tb/pmc_env.sv
`timescale 1ns/100ps
`default_nettype none

// Far side of the controller: supply rails, pins and the software that halts the CPU.
module pmc_env (
  input wire logic clock,
  input wire logic [4:0] lvl,
  input wire logic go,
  output logic supply_low,
  output logic detector_low,
  output logic supply_present,
  output logic wakeup_pin,
  output logic external_reset_pin_n,
  output logic cpu_wait
);
  // Pins move just after an edge, so they never race the synchronisers' sampling edge.
  always @(posedge clock) begin
    {external_reset_pin_n, wakeup_pin, supply_present, detector_low, supply_low} <= lvl;
  end

  // halt after select
  // Software only halts once the mode field has been written, so one wait pulse follows each go.
  always @(posedge clock) begin
    cpu_wait <= go;
  end
endmodule

`default_nettype wire

// file: tb/pmc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none

module pmc_top_tb;
  import pmc_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} pmc_row_t;
  logic clock = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0, wake_clk_req = 1'b0, go = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] ev_v = 4'h0;
  logic [4:0] lvl = 5'h14;
  logic supply_low, detector_low, supply_present, wakeup_pin, external_reset_pin_n, cpu_wait;
  pmc_power_t power;
  pmc_mode_t mode;
  logic [1:0] regulator_range, reference_level_select;
  logic [15:0] io_pull;
  logic system_reset, reset_pullup_en, io_analog, battery_select, charge_en, detector_irq;
  int miscompares = 0, checks = 0;
  // Plain register traffic: offset, write data, expected read back.
  pmc_row_t rows [7] = '{'{OFS_IO_PULL, 32'hffff_a5c3, 32'h0000_a5c3}, '{OFS_REFBUF, 32'h0, 32'h0},
    '{OFS_REFBUF, 32'h1, 32'h1}, '{OFS_REFBUF, 32'h2, 32'h2}, '{OFS_REFBUF, 32'h3, 32'h2},
    '{8'h10, 32'hffff_ffff, 32'h0}, '{OFS_CTRL, 32'h008, 32'h008}};

  pmc_env u_env (.clock(clock), .lvl(lvl), .go(go), .supply_low(supply_low), .detector_low(detector_low),
    .supply_present(supply_present), .wakeup_pin(wakeup_pin), .external_reset_pin_n(external_reset_pin_n),
    .cpu_wait(cpu_wait));
  pmc_top DUT (.clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cpu_wait(cpu_wait), .irq_event(ev_v[0]), .wake_clk_req(wake_clk_req), .independent_watchdog(ev_v[3]),
    .rtc_event(ev_v[1]), .slow_crystal_fail(ev_v[2]), .supply_low(supply_low), .detector_low(detector_low),
    .supply_present(supply_present), .wakeup_pin(wakeup_pin), .external_reset_pin_n(external_reset_pin_n),
    .power(power), .mode(mode), .regulator_range(regulator_range),
    .reference_level_select(reference_level_select), .io_pull(io_pull), .system_reset(system_reset),
    .reset_pullup_en(reset_pullup_en), .io_analog(io_analog), .battery_select(battery_select),
    .charge_en(charge_en), .detector_irq(detector_irq));

  // Free-running 20 MHz clock.
  always #25 clock = ~clock;

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so it is sampled just past that edge.
  task rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    addr <= a; rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task pl(input logic [3:0] v);
    @(posedge clock);
    ev_v <= v;
    @(posedge clock);
    ev_v <= 4'h0;
  endtask
  task sw_wait();
    @(posedge clock);
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
  endtask
  // Bounded wait for the mode to settle with reset released.
  task wm(input pmc_mode_t m);
    for (int i = 0; i < 16 && (mode !== m || system_reset !== 1'b0); i++) step(1);
    chk("mode", 32'(m), 32'(mode));
    chk("reset", 0, system_reset);
  endtask
  task results();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Watchdog against a hung sequence; the tests need well under 2000 cycles.
  initial begin
    #(20000 * 50);
    miscompares++;
    results();
  end

  initial begin
    step(6);
    srst <= 1'b0;
    wm(MODE_RUN);
    chk("io_analog", 1, io_analog);
    chk("range", 1, regulator_range);
    foreach (rows[i]) begin
      wreg(rows[i].a, rows[i].d);
      rchk(rows[i].a, rows[i].e);
      if (rows[i].a == OFS_REFBUF) chk("ref", rows[i].e, reference_level_select);
    end
    $display("register rows done");
    wreg(OFS_CTRL, 32'h008); sw_wait(); wm(MODE_SLEEP);
    chk("cpu_clk", 0, power.cpu_clk);
    pl(4'h1); wm(MODE_RUN);
    wreg(OFS_CTRL, 32'h00c); wm(MODE_LPRUN);
    sw_wait(); wm(MODE_LPSLEEP);
    pl(4'h1); wm(MODE_LPRUN);
    wreg(OFS_CTRL, 32'h008); wm(MODE_RUN);
    $display("sleep tests done");
    wreg(OFS_CTRL, 32'h009); sw_wait(); wm(MODE_STOP);
    chk("pll", 0, power.pll);
    chk("slow rc", 1, power.internal_rc_slow);
    wake_clk_req <= 1'b1; step(4);
    chk("fast rc", 1, power.internal_rc_fast);
    wake_clk_req <= 1'b0; pl(4'h1); wm(MODE_RUN);
    $display("stop test done");
    wreg(OFS_IO_PULL, 32'h00ff); wreg(OFS_CTRL, 32'h00a); sw_wait(); wm(MODE_STANDBY);
    chk("hiz", 1, power.regulator_hiz);
    chk("pulls", 1, power.io_pull_apply);
    chk("io_pull", 32'h00ff, 32'(io_pull));
    pl(4'h4); wm(MODE_RUN);
    wreg(OFS_CTRL, 32'h20a); sw_wait(); wm(MODE_STANDBY);
    lvl[3] <= 1'b1; wm(MODE_RUN);
    lvl[3] <= 1'b0;
    $display("standby tests done");
    wreg(OFS_CTRL, 32'h00b); sw_wait(); wm(MODE_SHUTDOWN);
    chk("bor", 0, power.supply_drop_reset);
    pl(4'h4); lvl[0] <= 1'b1; step(5);
    chk("mode", 32'(MODE_SHUTDOWN), 32'(mode));
    lvl[0] <= 1'b0; step(3);
    pl(4'h2); wm(MODE_RUN);
    $display("shutdown test done");
    lvl[2] <= 1'b0; wreg(OFS_CTRL, 32'h10a); step(4);
    chk("battery", 1, battery_select);
    chk("charge", 0, charge_en);
    sw_wait(); wm(MODE_STANDBY);
    pl(4'h2); step(4);
    chk("mode", 32'(MODE_STANDBY), 32'(mode));
    lvl[4] <= 1'b0; step(4);
    chk("pin reset", 1, system_reset);
    lvl[4] <= 1'b1; lvl[2] <= 1'b1; wm(MODE_RUN);
    wreg(OFS_CTRL, 32'h108); step(4);
    chk("charge", 1, charge_en);
    $display("battery test done");
    lvl[0] <= 1'b1; step(5);
    chk("drop reset", 1, system_reset);
    lvl[0] <= 1'b0; wm(MODE_RUN);
    pl(4'h8); #1;
    chk("wdg reset", 1, system_reset);
    chk("pull-up", 0, reset_pullup_en);
    chk("analog", 1, io_analog);
    $display("reset tests done");
    // Detector on entering low, flag clear, then leaving low with both edges enabled; status carries the watchdog cause.
    wm(MODE_RUN);
    wreg(OFS_CTRL, 32'h068); lvl[1] <= 1'b1; step(5);
    chk("detector irq", 1, detector_irq);
    rchk(OFS_STATUS, 32'h0000_00a8);
    wreg(OFS_STATUS, 32'h0000_0020); step(1);
    chk("detector irq", 0, detector_irq);
    wreg(OFS_CTRL, 32'h0e8); lvl[1] <= 1'b0; step(5);
    chk("detector irq", 1, detector_irq);
    rchk(OFS_STATUS, 32'h0000_00a0);
    $display("detector test done");
    // Falling wake edge leaves shutdown and records a wake exit.
    lvl[3] <= 1'b1; wreg(OFS_CTRL, 32'h60b); sw_wait(); wm(MODE_SHUTDOWN);
    lvl[3] <= 1'b0; wm(MODE_RUN);
    rchk(OFS_STATUS, 32'h0000_00c0);
    $display("wake polarity test done");
    // Reset in mid-run restores every register default.
    wreg(OFS_IO_PULL, 32'h1234); wreg(OFS_REFBUF, 32'h1);
    @(posedge clock);
    srst <= 1'b1;
    step(3);
    chk("reset analog", 1, io_analog);
    srst <= 1'b0;
    wm(MODE_RUN);
    chk("io_pull", 0, 32'(io_pull));
    chk("ref", 0, reference_level_select);
    chk("range", 1, regulator_range);
    $display("mid-run reset done");
    results();
  end
endmodule

`default_nettype wire
